// ### common/pors_pkg.sv
// Shared constants and types for the power-on and supply-monitor reset block
package pors_pkg;
    // Register addresses on the 8-bit register port
    localparam logic [7:0] ADDR_MON_CTL = 8'hff;
    localparam logic [7:0] ADDR_RST_SRC = 8'hef;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'he0;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'he1;

    // Field positions
    localparam int MON_EN_BIT = 7;
    localparam int MON_STAT_BIT = 6;
    localparam int POR_FLAG_BIT = 1;
    localparam int IRQ_TRIP_BIT = 0;
    localparam int IRQ_REL_BIT = 1;
    localparam int IRQ_W = 2;

    // Reset values
    localparam logic MON_EN_RST = 1'h0;
    localparam logic MON_SEL_RST = 1'h0;
    localparam logic POR_FLAG_RST = 1'h0;
    localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

    // Release delay after power-up; longest time, so the cycle count rounds down
    localparam int POR_DELAY_NS = 300000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int POR_DELAY_CYC = POR_DELAY_NS / CLK_PERIOD_NS;

    // Program start address after every reset
    localparam logic [15:0] BOOT_ADDR = 16'h0000;

    // Reset sequencing states
    typedef enum logic [1:0] {
        ST_POWER_UP = 2'h0,
        ST_DELAY = 2'h1,
        ST_RUN = 2'h2,
        ST_MON_HOLD = 2'h3
    } pors_state_t;

    // One register-port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pors_req_t;
endpackage

// ### hw/pors_top.sv
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
module pors_top #(
    parameter int POR_DELAY_CYC = pors_pkg::POR_DELAY_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire pors_pkg::pors_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire logic supply_above_thresh,
    input wire logic other_rst_req,
    output logic supply_monitor_on,
    output logic core_rst,
    output logic rst_pin_o,
    output logic rst_pin_oe,
    output logic power_on_reset_flag,
    output logic [15:0] boot_addr,
    output logic irq
);

    localparam int CW = $clog2(POR_DELAY_CYC + 1);
    localparam logic [CW-1:0] DELAY_LOAD = CW'(POR_DELAY_CYC - 1);

    pors_pkg::pors_state_t state_q;
    pors_pkg::pors_state_t state_d;
    logic [1:0] sync_q;
    logic supply_ok;
    logic [CW-1:0] cnt_q;
    logic mon_en_q;
    logic mon_sel_q;
    logic flag_q;
    logic [pors_pkg::IRQ_W-1:0] stat_q;
    logic [pors_pkg::IRQ_W-1:0] mask_q;
    logic [pors_pkg::IRQ_W-1:0] events;
    logic core_rst_q;
    logic pin_oe_q;
    logic irq_q;
    logic [7:0] rdata_q;
    logic mon_trip;
    logic delay_done;
    logic wr_ctl;
    logic wr_src;
    logic wr_mask;
    logic rd_stat;

    // Comparator output is analog-side; two flops before anything looks at it
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            sync_q <= 2'h0;
        else
            sync_q <= {sync_q[0], supply_above_thresh};
    end

    assign supply_ok = sync_q[1];

    // Register port decode
    assign wr_ctl = reg_req.wr && (reg_req.addr == pors_pkg::ADDR_MON_CTL);
    assign wr_src = reg_req.wr && (reg_req.addr == pors_pkg::ADDR_RST_SRC);
    assign wr_mask = reg_req.wr && (reg_req.addr == pors_pkg::ADDR_IRQ_MASK);
    assign rd_stat = reg_req.rd && (reg_req.addr == pors_pkg::ADDR_IRQ_STAT);

    // Monitor only resets the core once it is both on and selected
    assign mon_trip = (state_q == pors_pkg::ST_RUN) && mon_en_q && mon_sel_q && !supply_ok;
    assign delay_done = (cnt_q == '0);

    // Sequencer next state
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            pors_pkg::ST_POWER_UP:
            begin
                if (supply_ok)
                    state_d = pors_pkg::ST_DELAY;
            end
            pors_pkg::ST_DELAY:
            begin
                // A dip during the delay restarts the whole power-up
                if (!supply_ok)
                    state_d = pors_pkg::ST_POWER_UP;
                else if (delay_done)
                    state_d = pors_pkg::ST_RUN;
            end
            pors_pkg::ST_RUN:
            begin
                if (mon_trip)
                    state_d = pors_pkg::ST_MON_HOLD;
            end
            pors_pkg::ST_MON_HOLD:
            begin
                // Straight back to run, no power-up delay here
                if (supply_ok)
                    state_d = pors_pkg::ST_RUN;
            end
        endcase
    end

    // State register; only the power-up reset reaches it
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            state_q <= pors_pkg::ST_POWER_UP;
        else
            state_q <= state_d;
    end

    // Release delay counter, reloaded whenever the sequencer is outside ST_DELAY
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            cnt_q <= DELAY_LOAD;
        else if (state_q != pors_pkg::ST_DELAY)
            cnt_q <= DELAY_LOAD;
        else if (!delay_done)
            cnt_q <= cnt_q - CW'(1);
    end

    // Reset outputs follow the next state, so they drop on a clock edge
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            core_rst_q <= 1'h1;
            pin_oe_q <= 1'h1;
        end
        else
        begin
            core_rst_q <= (state_d != pors_pkg::ST_RUN);
            pin_oe_q <= (state_d != pors_pkg::ST_RUN);
        end
    end

    // Monitor enable survives everything except power-up
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            mon_en_q <= pors_pkg::MON_EN_RST;
        else if (wr_ctl)
            mon_en_q <= reg_req.wdata[pors_pkg::MON_EN_BIT];
    end

    // Source select; selecting before the monitor settles can reset the part
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            mon_sel_q <= pors_pkg::MON_SEL_RST;
        else if (wr_src)
            mon_sel_q <= reg_req.wdata[pors_pkg::POR_FLAG_BIT];
    end

    // Power-on flag: set on leaving the power-up delay, cleared by other resets
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            flag_q <= pors_pkg::POR_FLAG_RST;
        else if (state_q == pors_pkg::ST_DELAY && state_d == pors_pkg::ST_RUN)
            flag_q <= 1'h1;
        else if (mon_trip || other_rst_req)
            flag_q <= 1'h0;
    end

    // Events for the interrupt status
    always_comb
    begin
        events = '0;
        events[pors_pkg::IRQ_TRIP_BIT] = mon_trip;
        events[pors_pkg::IRQ_REL_BIT] = (state_q == pors_pkg::ST_MON_HOLD) && supply_ok;
    end

    // Sticky status, cleared by a read; a new event in that cycle still lands
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            stat_q <= pors_pkg::IRQ_RST;
        else if (rd_stat)
            stat_q <= events;
        else
            stat_q <= stat_q | events;
    end

    // Interrupt mask
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            mask_q <= pors_pkg::IRQ_RST;
        else if (wr_mask)
            mask_q <= reg_req.wdata[pors_pkg::IRQ_W-1:0];
    end

    // Level interrupt, registered from the status held before the edge
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            irq_q <= 1'h0;
        else
            irq_q <= |(stat_q & mask_q);
    end

    // Read data stands only in the cycle after the read strobe
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            rdata_q <= 8'h00;
        else if (!reg_req.rd)
            rdata_q <= 8'h00;
        else
        begin
            rdata_q <= 8'h00;
            unique case (reg_req.addr)
                pors_pkg::ADDR_MON_CTL:
                begin
                    rdata_q[pors_pkg::MON_EN_BIT] <= mon_en_q;
                    rdata_q[pors_pkg::MON_STAT_BIT] <= supply_ok;
                end
                pors_pkg::ADDR_RST_SRC:
                    rdata_q[pors_pkg::POR_FLAG_BIT] <= flag_q;
                pors_pkg::ADDR_IRQ_STAT:
                    rdata_q[pors_pkg::IRQ_W-1:0] <= stat_q;
                pors_pkg::ADDR_IRQ_MASK:
                    rdata_q[pors_pkg::IRQ_W-1:0] <= mask_q;
                default:
                    rdata_q <= 8'h00; // Unmapped reads as zero
            endcase
        end
    end

    // Output drive
    assign reg_rdata = rdata_q;
    assign supply_monitor_on = mon_en_q;
    assign core_rst = core_rst_q;
    assign rst_pin_o = 1'h0; // Open drain, only ever pulls low
    assign rst_pin_oe = pin_oe_q;
    assign power_on_reset_flag = flag_q;
    assign boot_addr = pors_pkg::BOOT_ADDR;
    assign irq = irq_q;

    // Checks

    a_powerup_hold: assert property (
        @(posedge clock) disable iff (sys_rst)
        (state_q == pors_pkg::ST_POWER_UP) |=> (core_rst && rst_pin_oe)
    ) else $error("Reset not held during power-up");

    a_delay_holds_reset: assert property (
        @(posedge clock) disable iff (sys_rst)
        (state_q == pors_pkg::ST_DELAY && !delay_done) |=> core_rst
    ) else $error("Reset released before delay expired");

    a_delay_start_full: assert property (
        @(posedge clock) disable iff (sys_rst)
        (state_q == pors_pkg::ST_POWER_UP && supply_ok) |=> (cnt_q == DELAY_LOAD)
    ) else $error("Delay counter not loaded at start");

    a_flag_on_exit: assert property (
        @(posedge clock) disable iff (sys_rst)
        (state_q == pors_pkg::ST_DELAY && supply_ok && delay_done)
            |=> (power_on_reset_flag && !core_rst)
    ) else $error("Flag or release missing after power-up delay");

    a_flag_cleared: assert property (
        @(posedge clock) disable iff (sys_rst)
        (other_rst_req && state_q != pors_pkg::ST_DELAY) |=> !power_on_reset_flag
    ) else $error("Flag not cleared by other reset");

    a_boot_address: assert property (
        @(posedge clock) disable iff (sys_rst)
        $fell(core_rst) |-> (boot_addr == 16'h0000)
    ) else $error("Wrong start address after reset");

    a_enable_kept: assert property (
        @(posedge clock) disable iff (sys_rst)
        (other_rst_req && !wr_ctl) |=> (supply_monitor_on == $past(supply_monitor_on))
    ) else $error("Monitor enable changed by other reset");

    a_enable_write: assert property (
        @(posedge clock) disable iff (sys_rst)
        wr_ctl |=> (supply_monitor_on == $past(reg_req.wdata[pors_pkg::MON_EN_BIT]))
    ) else $error("Monitor enable did not follow write");

    a_monitor_trip: assert property (
        @(posedge clock) disable iff (sys_rst)
        (state_q == pors_pkg::ST_RUN && mon_en_q && mon_sel_q && !supply_ok)
            |=> (core_rst && rst_pin_oe && state_q == pors_pkg::ST_MON_HOLD)
    ) else $error("Supply drop did not reset the core");

    a_no_trip_unselected: assert property (
        @(posedge clock) disable iff (sys_rst)
        (state_q == pors_pkg::ST_RUN && !mon_sel_q) |=> (state_q != pors_pkg::ST_MON_HOLD)
    ) else $error("Unselected monitor caused a reset");

    a_monitor_release: assert property (
        @(posedge clock) disable iff (sys_rst)
        (state_q == pors_pkg::ST_MON_HOLD && supply_ok) |=> (!core_rst && !rst_pin_oe)
    ) else $error("Monitor reset not released at once");

    a_delay_restart: assert property (
        @(posedge clock) disable iff (sys_rst)
        (state_q == pors_pkg::ST_DELAY && !supply_ok)
            |=> (state_q == pors_pkg::ST_POWER_UP && core_rst && !power_on_reset_flag)
    ) else $error("Supply dip during delay did not restart power-up");

    a_flag_readback: assert property (
        @(posedge clock) disable iff (sys_rst)
        (reg_req.rd && reg_req.addr == pors_pkg::ADDR_RST_SRC)
            |=> (reg_rdata[pors_pkg::POR_FLAG_BIT] == $past(power_on_reset_flag))
    ) else $error("Reset source read lost the power-on flag");

    a_trip_clears_flag: assert property (
        @(posedge clock) disable iff (sys_rst)
        (state_q == pors_pkg::ST_MON_HOLD) |-> !power_on_reset_flag
    ) else $error("Power-on flag set during monitor reset");

    a_enable_needed: assert property (
        @(posedge clock) disable iff (sys_rst)
        (state_q == pors_pkg::ST_RUN && !supply_monitor_on)
            |=> (state_q != pors_pkg::ST_MON_HOLD)
    ) else $error("Disabled monitor caused a reset");

endmodule // pors_top

// ### test/pors_supply_model.sv
`timescale 1ns/100ps
// Supply comparator and the pulled-up reset pin outside the block
module pors_supply_model (
    input wire logic clock,
    input wire logic supply_good,
    input wire logic rst_pin_o,
    input wire logic rst_pin_oe,
    output wire logic supply_above_thresh,
    output wire logic rst_pin_n
);
    logic above_q = 1'b0;

    // Comparator lags the supply by a cycle, so the sync path sees a real edge
    always_ff @(posedge clock)
    begin
        above_q <= supply_good;
    end

    // Pull-up wins whenever the block lets go of the pin
    assign supply_above_thresh = above_q;
    assign rst_pin_n = rst_pin_oe ? rst_pin_o : 1'b1;
endmodule // pors_supply_model

// ### test/testbench.sv
`timescale 1ns/100ps
module testbench;
    localparam int DLY = 20;
    logic clock;
    logic sys_rst;
    pors_pkg::pors_req_t req;
    logic [7:0] reg_rdata;
    logic good;
    logic above;
    logic other_rst_req;
    logic mon_on;
    logic core_rst;
    logic pin_o;
    logic pin_oe;
    wire pin_n;
    logic por_flag;
    logic [15:0] boot_addr;
    logic irq;
    logic [7:0] rdv;
    logic [1:0] mask;
    int n;
    int num_errors = 0;
    int n_tests = 0;

    // Counts a comparison; case inequality so an unknown never matches
    `define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

    // Short delay count keeps power-up brief; expectations use DLY
    pors_top #(
        .POR_DELAY_CYC(DLY)
    ) i_dut (
        .clock(clock),
        .sys_rst(sys_rst),
        .reg_req(req),
        .reg_rdata(reg_rdata),
        .supply_above_thresh(above),
        .other_rst_req(other_rst_req),
        .supply_monitor_on(mon_on),
        .core_rst(core_rst),
        .rst_pin_o(pin_o),
        .rst_pin_oe(pin_oe),
        .power_on_reset_flag(por_flag),
        .boot_addr(boot_addr),
        .irq(irq)
    );

    pors_supply_model i_supply (
        .clock(clock),
        .supply_good(good),
        .rst_pin_o(pin_o),
        .rst_pin_oe(pin_oe),
        .supply_above_thresh(above),
        .rst_pin_n(pin_n)
    );

    // 250 MHz system clock
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        req <= '0;
    endtask

    // Read data only stand in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req <= '0;
        @(negedge clock);
        v = reg_rdata;
    endtask

    // Bounded wait for the core reset to reach a level
    task automatic wait_rst(input logic v);
        n = 0;
        while (core_rst !== v && n < 100)
        begin
            @(negedge clock);
            n++;
        end
    endtask

    task automatic power_up();
        @(posedge clock);
        sys_rst <= 1'b1;
        good <= 1'b0;
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (10) @(negedge clock);
        `CHK({core_rst, pin_n, por_flag, mon_on, boot_addr}, 20'h80000)
        @(posedge clock);
        good <= 1'b1;
        wait_rst(1'b0);
        `CHK(n >= DLY && n <= DLY + 8, 1'b1)
        `CHK({pin_n, por_flag, boot_addr}, 18'h30000)
    endtask

    // Supply dip of len cycles; trip says whether the monitor should act
    task automatic dip(input int len, input logic trip);
        @(posedge clock);
        good <= 1'b0;
        repeat (len) @(negedge clock);
        `CHK({core_rst, pin_n, por_flag}, {trip, ~trip, 1'b0})
        @(posedge clock);
        good <= 1'b1;
        wait_rst(1'b0);
        `CHK(n <= 8, 1'b1)
    endtask

    // Main sequence: power-up twice, then monitor trips
    initial
    begin
        sys_rst = 1'b1;
        good = 1'b0;
        other_rst_req = 1'b0;
        req = '0;
        void'($urandom(93));
        for (int p = 0; p < 2; p++)
        begin
            power_up();
            rd(pors_pkg::ADDR_MON_CTL, rdv);
            `CHK(rdv, 8'h40)
            rd(pors_pkg::ADDR_RST_SRC, rdv);
            `CHK(rdv, 8'h02)
            wr(8'h10, 8'hff);
            rd(8'h10, rdv);
            `CHK(rdv, 8'h00)
            wr(pors_pkg::ADDR_MON_CTL, 8'hbf);
            rd(pors_pkg::ADDR_MON_CTL, rdv);
            `CHK({rdv, mon_on}, 9'h181)
            @(posedge clock);
            other_rst_req <= 1'b1;
            @(posedge clock);
            other_rst_req <= 1'b0;
            @(negedge clock);
            `CHK({por_flag, mon_on}, 2'b01)
            $display("test power_up %0d done", p);
        end
        dip(15, 1'b0);
        // Software waits out the monitor turn-on time before selecting it
        repeat (10) @(posedge clock);
        wr(pors_pkg::ADDR_RST_SRC, 8'h02);
        for (int k = 0; k < 4; k++)
        begin
            mask = (k == 0) ? 2'h0 : 2'($urandom);
            wr(pors_pkg::ADDR_IRQ_MASK, {6'h00, mask});
            dip(12 + int'($urandom % 20), 1'b1);
            @(negedge clock);
            `CHK({irq, mon_on}, {|mask, 1'b1})
            rd(pors_pkg::ADDR_IRQ_STAT, rdv);
            `CHK(rdv, 8'h03)
            @(negedge clock);
            `CHK(irq, 1'b0)
        end
        $display("test monitor trips done");
        wr(pors_pkg::ADDR_MON_CTL, 8'h00);
        dip(15, 1'b0);
        // Enabled but deselected again: the monitor must stay quiet
        wr(pors_pkg::ADDR_RST_SRC, 8'h00);
        wr(pors_pkg::ADDR_MON_CTL, 8'h80);
        dip(15, 1'b0);
        $display("test monitor off done");
        // Supply dip inside the release delay starts the power-up over
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (10) @(posedge clock);
        good <= 1'b0;
        repeat (6) @(posedge clock);
        good <= 1'b1;
        @(negedge clock);
        `CHK({core_rst, pin_n, por_flag}, 3'b100)
        wait_rst(1'b0);
        `CHK({n >= DLY && n <= DLY + 8, por_flag}, 2'b11)
        $display("test delay restart done");
        stop_test();
    end

    // Cuts a hang short; the whole run needs well under this span
    initial
    begin
        repeat (5000) @(posedge clock);
        num_errors++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        stop_test();
    end
endmodule // testbench
